// ==== hw/uresp_top.sv ====
// What this block does
// - In FIFO mode break flag shows the break status of the head character.
// - Break flagged when input stays low a whole character including parity and stop.
// - Framing-error flag, status bit 3, set when stop bit is not high.
// - After a framing error receiver waits for a high line before new start.
// - Non-FIFO mode: reading the bad character clears the framing-error flag.
// - FIFO mode: framing flag clears on read unless next character also bad.
// - Parity-error flag, status bit 2, set when parity mismatches the selected sense.
// - FIFO mode: parity flag clears on read unless next character also bad.
// - Non-FIFO mode: overrun flag, bit 1, set when unread character is overwritten.
// - Reading line status clears the overrun flag in both modes.
// - FIFO overrun only when full and another character completes; reported at once.
// - On FIFO overrun the new character stays out of the full FIFO.
// - Interrupt while framing, parity or overrun flag set and line irq enabled.
`timescale 1ns/100ps
module uresp_top
  import uresp_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        rx_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rd_data_o,
  output logic             irq_o
);
  logic                rx_meta;
  logic                rx_sync;
  logic [15:0]         divisor;
  logic                fifo_en;
  logic                parity_en;
  logic                even_parity_select;
  logic                line_status_irq_enable;
  logic                overrun_flag;
  logic [EV_W-1:0]     irq_status;
  logic [EV_W-1:0]     irq_mask;
  logic [ENT_W-1:0]    mem [FIFO_DEPTH];
  logic [PTR_W-1:0]    wr_ptr;
  logic [PTR_W-1:0]    rd_ptr;
  logic [CNT_W-1:0]    count;
  logic [31:0]         next_rd_data;
  logic [CNT_W-1:0]    next_count;

  uresp_char_if chr ();

  uresp_rx_shift u_rx (
    .sys_clk_i            (sys_clk_i),
    .rst_b_i              (rst_b_i),
    .rx_sync_i            (rx_sync),
    .divisor_i            (divisor),
    .parity_en_i          (parity_en),
    .even_parity_select_i (even_parity_select),
    .chr                  (chr)
  );

  // Pin crosses into the clock domain through two flops
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_i;
      rx_sync <= rx_meta;
    end
  end

  // Register decode
  wire sel_rx_buf    = (addr_i == OFF_RX_BUF);
  wire sel_irq_en    = (addr_i == OFF_IRQ_EN);
  wire sel_line_ctrl = (addr_i == OFF_LINE_CTRL);
  wire sel_line_stat = (addr_i == OFF_LINE_STAT);
  wire sel_divisor   = (addr_i == OFF_DIVISOR);
  wire sel_irq_stat  = (addr_i == OFF_IRQ_STAT);
  wire sel_irq_mask  = (addr_i == OFF_IRQ_MASK);

  wire wr_line_ctrl  = wr_i && sel_line_ctrl;
  wire lsr_rd        = rd_i && sel_line_stat;
  // Mode switch flushes stale characters rather than mix two storage models
  wire mode_change   = wr_line_ctrl && (wr_data_i[LC_FIFO_EN] != fifo_en);

  // Receive storage control
  wire                 not_empty = (count != '0);
  wire                 pop       = rd_i && sel_rx_buf && not_empty;
  wire                 full_now  = fifo_en ? (count == CNT_W'(FIFO_DEPTH)) : not_empty;
  wire                 overrun_ev = chr.valid && full_now && !pop;
  wire                 push      = chr.valid && !full_now || chr.valid && full_now && pop;
  // Non-FIFO overrun: the new character replaces the unread one
  wire                 overwrite = overrun_ev && !fifo_en;
  wire [ENT_W-1:0]     new_entry = {chr.brk, chr.framing_err, chr.parity_err, chr.data};
  wire [ENT_W-1:0]     head      = mem[rd_ptr];
  wire                 err_char  = chr.valid && (chr.brk || chr.framing_err || chr.parity_err);

  // Flags follow whichever character sits at the head
  wire                 head_pe   = not_empty && head[ENT_PE];
  wire                 head_fe   = not_empty && head[ENT_FE];
  wire                 head_bi   = not_empty && head[ENT_BI];

  wire [31:0]          line_status = {27'h0000000, head_bi, head_fe, head_pe, overrun_flag, not_empty};
  wire [EV_W-1:0]      ev_set    = {err_char, overrun_ev, push};
  wire [EV_W-1:0]      ev_clr    = (wr_i && sel_irq_stat) ? wr_data_i[EV_W-1:0] : '0;
  wire                 line_irq  = line_status_irq_enable && (overrun_flag || head_pe || head_fe || head_bi);
  wire                 next_irq  = line_irq || |(irq_status & irq_mask);

  always_comb begin
    next_count = count;
    if (push && !pop)
      next_count = count + CNT_W'(1);
    else if (pop && !push)
      next_count = count - CNT_W'(1);
  end

  always_comb begin
    next_rd_data = 32'h00000000;
    if (rd_i) begin
      if (sel_rx_buf)
        next_rd_data = not_empty ? {24'h000000, head[7:0]} : 32'h00000000;
      else if (sel_irq_en)
        next_rd_data = 32'(line_status_irq_enable) << IE_LINE_STAT;
      else if (sel_line_ctrl)
        next_rd_data = (32'(fifo_en) << LC_FIFO_EN) | (32'(parity_en) << LC_PARITY_EN)
                     | (32'(even_parity_select) << LC_EVEN_PAR);
      else if (sel_line_stat)
        next_rd_data = line_status;
      else if (sel_divisor)
        next_rd_data = {16'h0000, divisor};
      else if (sel_irq_stat)
        next_rd_data = 32'(irq_status);
      else if (sel_irq_mask)
        next_rd_data = 32'(irq_mask);
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      divisor                <= DIVISOR_RST;
      {even_parity_select, parity_en, fifo_en} <= LINE_CTRL_RST;
      line_status_irq_enable <= 1'b0;
      irq_mask               <= IRQ_MASK_RST;
    end else if (wr_i) begin
      if (sel_divisor)
        divisor <= wr_data_i[15:0];
      if (sel_line_ctrl) begin
        fifo_en            <= wr_data_i[LC_FIFO_EN];
        parity_en          <= wr_data_i[LC_PARITY_EN];
        even_parity_select <= wr_data_i[LC_EVEN_PAR];
      end
      if (sel_irq_en)
        line_status_irq_enable <= wr_data_i[IE_LINE_STAT];
      if (sel_irq_mask)
        irq_mask <= wr_data_i[EV_W-1:0];
    end
  end

  // Receive storage pointers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (mode_change) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + PTR_W'(1);
      if (pop)
        rd_ptr <= rd_ptr + PTR_W'(1);
      count <= next_count;
    end
  end

  // Full FIFO drops the new character; it only lives in the shift path
  always_ff @(posedge sys_clk_i) begin
    if (push)
      mem[wr_ptr] <= new_entry;
    else if (overwrite)
      mem[rd_ptr] <= new_entry;
  end

  // Overrun: new event wins over the clearing read
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      overrun_flag <= 1'b0;
    else
      overrun_flag <= overrun_ev || (overrun_flag && !lsr_rd);
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      irq_status <= '0;
    else
      irq_status <= ev_set | (irq_status & ~ev_clr);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 32'h00000000;
      irq_o     <= 1'b0;
    end else begin
      rd_data_o <= next_rd_data;
      irq_o     <= next_irq;
    end
  end
endmodule

// ==== hw/uresp_pkg.sv ====
package uresp_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFF_RX_BUF     = 8'h00;
  localparam logic [7:0]  OFF_IRQ_EN     = 8'h04;
  localparam logic [7:0]  OFF_LINE_CTRL  = 8'h08;
  localparam logic [7:0]  OFF_LINE_STAT  = 8'h0c;
  localparam logic [7:0]  OFF_DIVISOR    = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;

  // Line status fields
  localparam int          LS_DATA_READY  = 0;
  localparam int          LS_OVERRUN     = 1;
  localparam int          LS_PARITY_ERR  = 2;
  localparam int          LS_FRAMING_ERR = 3;
  localparam int          LS_BREAK       = 4;

  // Line control fields
  localparam int          LC_FIFO_EN     = 0;
  localparam int          LC_PARITY_EN   = 3;
  localparam int          LC_EVEN_PAR    = 4;

  // Interrupt enable field
  localparam int          IE_LINE_STAT   = 2;

  // Sticky event bits
  localparam int          EV_CHAR        = 0;
  localparam int          EV_OVERRUN     = 1;
  localparam int          EV_ERR_CHAR    = 2;
  localparam int          EV_W           = 3;

  // FIFO entry layout: data plus per-character status
  localparam int          FIFO_DEPTH     = 16;
  localparam int          PTR_W          = 4;
  localparam int          CNT_W          = 5;
  localparam int          ENT_PE         = 8;
  localparam int          ENT_FE         = 9;
  localparam int          ENT_BI         = 10;
  localparam int          ENT_W          = 11;

  // Reset values
  localparam logic [15:0] DIVISOR_RST    = 16'h0001;
  localparam logic [2:0]  LINE_CTRL_RST  = 3'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;

  // Bit timing, in ticks of the oversampling clock, and the index of the last data bit
  localparam logic [3:0]  OVS_LAST       = 4'hf;
  localparam logic [3:0]  OVS_MID        = 4'h7;
  localparam logic [2:0]  DATA_LAST      = 3'h7;

  typedef enum logic [2:0] {
    URESP_IDLE   = 3'b000,
    URESP_START  = 3'b001,
    URESP_DATA   = 3'b011,
    URESP_PARITY = 3'b010,
    URESP_STOP   = 3'b110,
    URESP_WAIT   = 3'b111
  } uresp_rx_state_t;
endpackage

// ==== hw/uresp_char_if.sv ====
`timescale 1ns/100ps
interface uresp_char_if;
  logic       valid;
  logic [7:0] data;
  logic       parity_err;
  logic       framing_err;
  logic       brk;
  modport src  (output valid, output data, output parity_err, output framing_err, output brk);
  modport sink (input valid, input data, input parity_err, input framing_err, input brk);
endinterface

// ==== hw/uresp_rx_shift.sv ====
`timescale 1ns/100ps
module uresp_rx_shift
  import uresp_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        rx_sync_i,
  input  wire logic [15:0] divisor_i,
  input  wire logic        parity_en_i,
  input  wire logic        even_parity_select_i,
  uresp_char_if.src        chr
);
  uresp_rx_state_t state;
  uresp_rx_state_t next_state;
  logic [15:0]     baud_cnt;
  logic [3:0]      ovs_cnt;
  logic [2:0]      bit_cnt;
  logic [7:0]      shift;
  logic            par_bit;

  wire        tick      = (baud_cnt == 16'h0000);
  wire [15:0] reload    = (divisor_i == 16'h0000) ? 16'h0000 : divisor_i - 16'h0001;
  wire        bit_done  = tick && (ovs_cnt == OVS_LAST);
  wire        mid_start = tick && (ovs_cnt == OVS_MID);
  wire        par_calc  = ^{shift, par_bit};
  wire        stop_bad  = !rx_sync_i;

  always_comb begin
    next_state = state;
    case (state)
      URESP_IDLE:   if (!rx_sync_i) next_state = URESP_START;
      URESP_START:  if (mid_start) next_state = rx_sync_i ? URESP_IDLE : URESP_DATA;
      URESP_DATA:   if (bit_done && bit_cnt == DATA_LAST) next_state = parity_en_i ? URESP_PARITY : URESP_STOP;
      URESP_PARITY: if (bit_done) next_state = URESP_STOP;
      // Bad stop bit: hold off until the line idles high
      URESP_STOP:   if (bit_done) next_state = stop_bad ? URESP_WAIT : URESP_IDLE;
      URESP_WAIT:   if (rx_sync_i) next_state = URESP_IDLE;
      default:      next_state = URESP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state    <= URESP_IDLE;
      baud_cnt <= 16'h0000;
      ovs_cnt  <= 4'h0;
      bit_cnt  <= 3'h0;
      shift    <= 8'h00;
      par_bit  <= 1'b0;
    end else begin
      state    <= next_state;
      baud_cnt <= tick ? reload : baud_cnt - 16'h0001;
      // Start phase realigns the oversampler so later samples land mid bit
      if (state == URESP_IDLE || mid_start && state == URESP_START)
        ovs_cnt <= 4'h0;
      else if (tick)
        ovs_cnt <= ovs_cnt + 4'h1;
      if (state != URESP_DATA)
        bit_cnt <= 3'h0;
      else if (bit_done)
        bit_cnt <= bit_cnt + 3'h1;
      if (state == URESP_START)
        par_bit <= 1'b0;
      if (bit_done && state == URESP_DATA)
        shift <= {rx_sync_i, shift[7:1]};
      if (bit_done && state == URESP_PARITY)
        par_bit <= rx_sync_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chr.valid       <= 1'b0;
      chr.data        <= 8'h00;
      chr.parity_err  <= 1'b0;
      chr.framing_err <= 1'b0;
      chr.brk         <= 1'b0;
    end else begin
      chr.valid <= bit_done && state == URESP_STOP;
      if (bit_done && state == URESP_STOP) begin
        chr.data        <= shift;
        chr.parity_err  <= parity_en_i && !(par_calc ^ even_parity_select_i);
        chr.framing_err <= stop_bad;
        // Line low through start, data, parity and stop
        chr.brk         <= stop_bad && shift == 8'h00 && !par_bit;
      end
    end
  end
endmodule

// ==== verification/uresp_tx_model.sv ====
`timescale 1ns/100ps
module uresp_tx_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic sys_clk_i,
  output logic      tx_o
);
  // Idle level is high, as a pulled-up pin would rest
  initial tx_o = 1'b1;

  // Bit length follows the divisor the bench programs
  int bit_cyc = BIT_CYC;

  task automatic line(input logic v, input int n);
    tx_o <= v;
    repeat (n * bit_cyc) @(posedge sys_clk_i);
  endtask

  // Start, 8 data LSB first, optional parity, stop; line left at stop level
  task automatic send(input logic [7:0] d, input logic par_on, input logic par_v, input logic stop_v);
    @(posedge sys_clk_i);
    line(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      line(d[i], 1);
    end
    if (par_on) begin
      line(par_v, 1);
    end
    line(stop_v, 1);
  endtask
endmodule

// ==== verification/uresp_top_sva.sv ====
`timescale 1ns/100ps
module uresp_top_sva
  import uresp_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        rx_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        irq_o
);
  logic          ie_q;
  logic [EV_W-1:0] mask_q;
  logic [7:0]    hi_cnt;
  logic          oe_seen;
  logic          st_q;
  logic          un_q;
  logic          rb_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Idle count saturates; 255 quiet cycles cover a pending stop bit only at small divisors
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ie_q    <= 1'b0;
      mask_q  <= '0;
      hi_cnt  <= 8'h00;
      oe_seen <= 1'b0;
      st_q    <= 1'b0;
      un_q    <= 1'b0;
      rb_q    <= 1'b0;
    end else begin
      st_q   <= rd_i && addr_i == OFF_LINE_STAT;
      un_q   <= rd_i && addr_i > OFF_IRQ_MASK;
      rb_q   <= rd_i && addr_i == OFF_RX_BUF;
      hi_cnt <= !rx_i ? 8'h00 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 8'h01);
      if (wr_i && addr_i == OFF_IRQ_EN) begin
        ie_q <= wr_data_i[IE_LINE_STAT];
      end
      if (wr_i && addr_i == OFF_IRQ_MASK) begin
        mask_q <= wr_data_i[EV_W-1:0];
      end
      // Any line activity may bring a fresh overrun, so it voids the last read
      if (!rx_i) begin
        oe_seen <= 1'b0;
      end else if (st_q) begin
        oe_seen <= rd_data_o[LS_OVERRUN] && hi_cnt == 8'hff;
      end
    end
  end

  a_rd_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_unmapped_zero: assert property (un_q |-> rd_data_o == 32'h0)
    else $error("unmapped read not zero");
  a_stat_upper_zero: assert property (st_q |-> rd_data_o[31:5] == 27'h0)
    else $error("status upper bits not zero");
  a_buf_byte_only: assert property (rb_q |-> rd_data_o[31:8] == 24'h0)
    else $error("buffer upper bits not zero");
  a_flag_needs_char: assert property (st_q && |rd_data_o[4:2] |-> rd_data_o[LS_DATA_READY])
    else $error("error flag without a head character");
  a_irq_quiet_off: assert property (!ie_q && mask_q == '0 && !$past(ie_q) && $past(mask_q) == '0 |-> !irq_o)
    else $error("interrupt with all enables off");
  a_irq_on_flag: assert property (st_q && |rd_data_o[4:1] && ie_q && $past(ie_q, 2) |-> irq_o)
    else $error("line flag set but no interrupt");
  a_oe_read_clear: assert property (st_q && oe_seen |-> !rd_data_o[LS_OVERRUN])
    else $error("overrun not cleared by status read");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !irq_o && rd_data_o == 32'h0)
    else $error("outputs not quiet after reset");

  c_frame_seen: cover property (st_q && rd_data_o[LS_FRAMING_ERR]);
  c_parity_seen: cover property (st_q && rd_data_o[LS_PARITY_ERR]);
  c_overrun_seen: cover property (st_q && rd_data_o[LS_OVERRUN]);
  c_brk_seen: cover property (st_q && rd_data_o[LS_BREAK]);
endmodule

bind uresp_top uresp_top_sva u_sva (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .rx_i(rx_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o)
);

// ==== verification/uart_receive_error_status_bench.sv ====
`timescale 1ns/100ps
module uart_receive_error_status_bench
  import uresp_pkg::*;
;
  localparam logic [31:0] S_RDY = 32'h1 << LS_DATA_READY;
  localparam logic [31:0] S_OVR = 32'h1 << LS_OVERRUN;
  localparam logic [31:0] S_PAR = 32'h1 << LS_PARITY_ERR;
  localparam logic [31:0] S_FRM = 32'h1 << LS_FRAMING_ERR;
  localparam logic [31:0] S_BRK = 32'h1 << LS_BREAK;

  logic        sys_clk_i;
  logic        rst_b_i;
  logic        rx_line;
  logic [7:0]  addr_i;
  logic [31:0] wr_data_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rd_data_o;
  logic        irq_o;
  logic [31:0] got;
  int          n_fail;
  int          checks_done;

  uresp_top DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .rx_i(rx_line), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o));
  uresp_tx_model #(.BIT_CYC(16)) tx (.sys_clk_i(sys_clk_i), .tx_o(rx_line));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic par(input logic [7:0] d, input logic even);
    return even ? ^d : ~^d;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // Answer stands one cycle only, so it is taken mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = rd_data_o;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, got);
    chk(got, e);
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask

  task automatic t_reset();
    rd_chk(OFF_LINE_STAT, 32'h0);
    rd_chk(OFF_RX_BUF, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
    rd_chk(OFF_LINE_CTRL, 32'h0);
    irq_chk(1'b0);
  endtask

  task automatic t_frame();
    wr(OFF_IRQ_EN, 32'h1 << IE_LINE_STAT);
    rd_chk(OFF_IRQ_EN, 32'h1 << IE_LINE_STAT);
    tx.send(8'ha5, 1'b0, 1'b0, 1'b0);
    tx.line(1'b0, 3);
    tx.line(1'b1, 1);
    rd_chk(OFF_LINE_STAT, S_RDY | S_FRM);
    irq_chk(1'b1);
    rd_chk(OFF_RX_BUF, 32'ha5);
    rd_chk(OFF_LINE_STAT, 32'h0);
    irq_chk(1'b0);
    tx.send(8'h3c, 1'b0, 1'b0, 1'b1);
    rd_chk(OFF_RX_BUF, 32'h3c);
    rd_chk(OFF_IRQ_STAT, 32'h5);
    wr(OFF_IRQ_EN, 32'h0);
    wr(OFF_IRQ_MASK, 32'h4);
    rd_chk(OFF_IRQ_MASK, 32'h4);
    irq_chk(1'b1);
    wr(OFF_IRQ_STAT, 32'h7);
    irq_chk(1'b0);
    rd_chk(OFF_IRQ_STAT, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0);
  endtask

  task automatic t_parity();
    for (int e = 0; e < 2; e++) begin
      wr(OFF_LINE_CTRL, (32'h1 << LC_PARITY_EN) | (32'(e) << LC_EVEN_PAR));
      tx.send(8'h96, 1'b1, par(8'h96, e[0]), 1'b1);
      rd_chk(OFF_LINE_STAT, S_RDY);
      rd_chk(OFF_RX_BUF, 32'h96);
      tx.send(8'h13, 1'b1, ~par(8'h13, e[0]), 1'b1);
      rd_chk(OFF_LINE_STAT, S_RDY | S_PAR);
      rd_chk(OFF_RX_BUF, 32'h13);
    end
  endtask

  task automatic t_overrun();
    wr(OFF_LINE_CTRL, 32'h0);
    tx.send(8'h11, 1'b0, 1'b0, 1'b1);
    tx.send(8'h22, 1'b0, 1'b0, 1'b1);
    // Quiet line first, so the checker can judge the clearing read
    repeat (260) @(posedge sys_clk_i);
    rd_chk(OFF_LINE_STAT, S_RDY | S_OVR);
    rd_chk(OFF_LINE_STAT, S_RDY);
    rd_chk(OFF_RX_BUF, 32'h22);
  endtask

  task automatic t_fifo();
    logic [31:0] st [5] = '{S_RDY, S_RDY | S_PAR, S_RDY | S_FRM, S_RDY | S_BRK, S_RDY};
    logic [7:0]  dat [5] = '{8'h41, 8'h42, 8'h43, 8'h00, 8'h44};
    wr(OFF_LINE_CTRL, (32'h1 << LC_FIFO_EN) | (32'h1 << LC_PARITY_EN) | (32'h1 << LC_EVEN_PAR));
    tx.send(8'h41, 1'b1, par(8'h41, 1'b1), 1'b1);
    tx.send(8'h42, 1'b1, ~par(8'h42, 1'b1), 1'b1);
    tx.send(8'h43, 1'b1, par(8'h43, 1'b1), 1'b0);
    tx.line(1'b1, 1);
    tx.send(8'h00, 1'b1, 1'b0, 1'b0);
    tx.line(1'b0, 2);
    tx.line(1'b1, 1);
    tx.send(8'h44, 1'b1, par(8'h44, 1'b1), 1'b1);
    // Framing may ride along with the all-low character, so it is not judged there
    for (int i = 0; i < 5; i++) begin
      rd(OFF_LINE_STAT, got);
      chk(got & (i == 3 ? ~S_FRM : 32'hffff_ffff), st[i]);
      rd_chk(OFF_RX_BUF, {24'h0, dat[i]});
    end
    rd_chk(OFF_LINE_STAT, 32'h0);
  endtask

  task automatic t_fifo_full();
    wr(OFF_LINE_CTRL, 32'h1 << LC_FIFO_EN);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      tx.send(8'(8'h60 + i), 1'b0, 1'b0, 1'b1);
    end
    rd_chk(OFF_LINE_STAT, S_RDY);
    tx.send(8'h7f, 1'b0, 1'b0, 1'b1);
    rd_chk(OFF_LINE_STAT, S_RDY | S_OVR);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd_chk(OFF_RX_BUF, 32'h60 + i);
    end
    rd_chk(OFF_LINE_STAT, 32'h0);
  endtask

  // Slower bit clock: oversampler must track a divisor other than one
  task automatic t_divisor();
    wr(OFF_DIVISOR, 32'h2);
    rd_chk(OFF_DIVISOR, 32'h2);
    rd_chk(OFF_LINE_CTRL, 32'h1 << LC_FIFO_EN);
    tx.bit_cyc = 32;
    tx.send(8'h5a, 1'b0, 1'b0, 1'b1);
    rd_chk(OFF_LINE_STAT, S_RDY);
    rd_chk(OFF_RX_BUF, 32'h5a);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // About 32 frames of 180 cycles plus register traffic; triple margin
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail      = 0;
    checks_done = 0;
    rst_b_i     = 1'b0;
    addr_i      = 8'h00;
    wr_data_i   = 32'h0;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_frame();
    t_parity();
    t_overrun();
    t_fifo();
    t_fifo_full();
    t_divisor();
    complete_run();
  end
endmodule
